//--- cpm_pulse_out.v
// pulse generator outputs and real-time monitor of the compute engine
//
// Summary of operation
// RULE_01: four independent pulse outputs are provided
// RULE_02: each pulse may raise a processor interrupt
// RULE_03: one polarity bit sets all pulse levels
// RULE_04: aux pulses go to shared io six, seven
// RULE_05: aux pulses update at most once per pass
// RULE_06: real and reactive pulses follow energy signs
// RULE_07: each pass stores sign bits in eight-entry fifo
// RULE_08: buffered signs leave at a fixed interval
// RULE_09: firmware configures outputs matching engine program
// RULE_10: aux pulses carry zero crossing and sag
// RULE_11: monitor samples four words at sample rate
// RULE_12: monitor streams four words at pass start
// RULE_13: enable bit turns monitor output on, off
// RULE_14: monitor bits shift on test clock edges
// RULE_15: each word is 35 slots with flag
// RULE_16: multiplexer frame lasts 13 slow clock cycles
// RULE_17: one sign per sub-interval, emptying before refill
// RULE_18: words msb first after flag, in order
`timescale 1ns/10ps
`include "cpm_map.vh"
module cpm_pulse_out #(
  parameter RELEASE_CYCLES = `CPM_RELEASE_CYCLES
) (
  // clock, reset, enable
  input wire I_SYS_CLK,
  input wire I_RSTN,
  input wire I_CE,
  // engine pass and exported signs
  input wire I_PASS_START,
  input wire I_SIGN_STROBE,
  input wire I_REAL_SIGN,
  input wire I_REACT_SIGN,
  input wire I_AUX_STROBE,
  input wire I_AUX_FIRST,
  input wire I_AUX_SECOND,
  // configuration
  input wire I_PULSE_POLARITY_INVERT,
  input wire [3:0] I_IRQ_ENABLE,
  input wire I_MONITOR_ENABLE,
  // monitored shared ram words
  input wire I_MON_SAMPLE,
  input wire [31:0] I_MON_WORD0,
  input wire [31:0] I_MON_WORD1,
  input wire [31:0] I_MON_WORD2,
  input wire [31:0] I_MON_WORD3,
  // external clocks on pins
  input wire I_SLOW_32K_CLOCK,
  input wire I_TEST_CLOCK,
  // pulse pins and interrupts
  output reg O_REACTIVE_ENERGY_PULSE,
  output reg O_REAL_ENERGY_PULSE,
  output reg O_LCD_SHARED_IO_6,
  output reg O_LCD_SHARED_IO_7,
  output reg [3:0] O_PULSE_IRQ,
  // monitor pin
  output wire O_TEST_MUX_OUT_PIN,
  output wire O_MONITOR_BUSY
);

localparam [31:0] RELEASE_SPAN = RELEASE_CYCLES - 1;
localparam [15:0] RELEASE_LAST = RELEASE_SPAN[15:0];

// pin level for an active flag; default polarity is active low
function pin_level;
  input active;
  input invert;
  begin
    pin_level = invert ? active : ~active; // RULE_03
  end
endfunction

// ----------------------------------------------------------------
// pin synchronisers and edge detection
// ----------------------------------------------------------------
reg [2:0] slow_sync;
reg [2:0] test_sync;
wire slow_rise = slow_sync[1] & ~slow_sync[2];
wire test_rise = test_sync[1] & ~test_sync[2];

always @(posedge I_SYS_CLK or negedge I_RSTN) begin
  if (!I_RSTN) begin
    slow_sync <= 3'h0;
    test_sync <= 3'h0;
  end else if (I_CE) begin
    slow_sync <= {slow_sync[1:0], I_SLOW_32K_CLOCK};
    test_sync <= {test_sync[1:0], I_TEST_CLOCK};
  end
end

// ----------------------------------------------------------------
// multiplexer frame and release slots
// ----------------------------------------------------------------
reg [3:0] frame_cnt;
reg [15:0] slot_timer;
reg release_tick;
wire frame_start = slow_rise && frame_cnt == `CPM_FRAME_CNT_LAST;

always @(posedge I_SYS_CLK or negedge I_RSTN) begin
  if (!I_RSTN) begin
    frame_cnt <= 4'h0;
    slot_timer <= 16'h0;
    release_tick <= 1'b0;
  end else if (I_CE) begin
    if (slow_rise) begin
      frame_cnt <= (frame_cnt == `CPM_FRAME_CNT_LAST) ? 4'h0 : frame_cnt + 4'h1; // RULE_16
    end
    // slots are realigned to every frame so the fixed interval never drifts
    if (frame_start || slot_timer == RELEASE_LAST) begin
      slot_timer <= 16'h0; // RULE_08
    end else begin
      slot_timer <= slot_timer + 16'h1;
    end
    release_tick <= frame_start || slot_timer == RELEASE_LAST; // RULE_17
  end
end

// ----------------------------------------------------------------
// sign fifo for real and reactive pulses
// ----------------------------------------------------------------
reg [1:0] fifo_mem [0:`CPM_FIFO_DEPTH-1];
reg [2:0] wr_ptr;
reg [2:0] rd_ptr;
reg [3:0] fifo_cnt;
wire fifo_full = fifo_cnt == `CPM_FIFO_FULL_CNT;
wire fifo_empty = fifo_cnt == 4'h0;
// a push while full is dropped: the engine overran its own pacing
wire push = I_SIGN_STROBE && !fifo_full;
wire pop = release_tick && !fifo_empty;

always @(posedge I_SYS_CLK) begin
  if (I_CE && push) begin
    fifo_mem[wr_ptr] <= {I_REACT_SIGN, I_REAL_SIGN}; // RULE_07
  end
end

always @(posedge I_SYS_CLK or negedge I_RSTN) begin
  if (!I_RSTN) begin
    wr_ptr <= 3'h0;
    rd_ptr <= 3'h0;
    fifo_cnt <= 4'h0;
  end else if (I_CE) begin
    if (push) begin
      wr_ptr <= wr_ptr + 3'h1;
    end
    if (pop) begin
      rd_ptr <= rd_ptr + 3'h1;
    end
    case ({push, pop})
      2'b10: fifo_cnt <= fifo_cnt + 4'h1;
      2'b01: fifo_cnt <= fifo_cnt - 4'h1;
      default: fifo_cnt <= fifo_cnt;
    endcase
  end
end

// ----------------------------------------------------------------
// pulse flags
// ----------------------------------------------------------------
reg [3:0] pulse_active;
reg aux_done;
wire [1:0] head = fifo_mem[rd_ptr];

always @(posedge I_SYS_CLK or negedge I_RSTN) begin
  if (!I_RSTN) begin
    pulse_active <= 4'h0;
    aux_done <= 1'b0;
  end else if (I_CE) begin
    if (pop) begin
      pulse_active[`CPM_CH_REAL] <= head[`CPM_FIFO_REAL]; // RULE_06
      pulse_active[`CPM_CH_REACT] <= head[`CPM_FIFO_REACT]; // RULE_06
    end
    // an update in the pass-start cycle belongs to the new pass
    if (I_AUX_STROBE && (!aux_done || I_PASS_START)) begin
      pulse_active[`CPM_CH_AUX1] <= I_AUX_FIRST; // RULE_10
      pulse_active[`CPM_CH_AUX2] <= I_AUX_SECOND; // RULE_10
      aux_done <= 1'b1; // RULE_05
    end else if (I_PASS_START) begin
      aux_done <= 1'b0; // RULE_05
    end
  end
end

// ----------------------------------------------------------------
// pin drivers and interrupt requests
// ----------------------------------------------------------------
reg [3:0] active_dly;

always @(posedge I_SYS_CLK or negedge I_RSTN) begin
  if (!I_RSTN) begin
    O_REACTIVE_ENERGY_PULSE <= 1'b1;
    O_REAL_ENERGY_PULSE <= 1'b1;
    O_LCD_SHARED_IO_6 <= 1'b1;
    O_LCD_SHARED_IO_7 <= 1'b1;
    active_dly <= 4'h0;
  end else if (I_CE) begin
    O_REACTIVE_ENERGY_PULSE <= pin_level(pulse_active[`CPM_CH_REACT],
                                         I_PULSE_POLARITY_INVERT); // RULE_01
    O_REAL_ENERGY_PULSE <= pin_level(pulse_active[`CPM_CH_REAL], I_PULSE_POLARITY_INVERT);
    O_LCD_SHARED_IO_6 <= pin_level(pulse_active[`CPM_CH_AUX1], I_PULSE_POLARITY_INVERT); // RULE_04
    O_LCD_SHARED_IO_7 <= pin_level(pulse_active[`CPM_CH_AUX2], I_PULSE_POLARITY_INVERT); // RULE_04
    active_dly <= pulse_active;
  end
end

genvar g;
generate
  for (g = 0; g < `CPM_NUM_PULSES; g = g + 1) begin : gen_irq
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
        O_PULSE_IRQ[g] <= 1'b0;
      end else if (I_CE) begin
        O_PULSE_IRQ[g] <= I_IRQ_ENABLE[g] && pulse_active[g] && !active_dly[g]; // RULE_02
      end
    end
  end
endgenerate

// ----------------------------------------------------------------
// real-time monitor
// ----------------------------------------------------------------
reg [31:0] mon_snap0;
reg [31:0] mon_snap1;
reg [31:0] mon_snap2;
reg [31:0] mon_snap3;
reg mon_busy_q;

// the snapshot freezes while a stream runs so words are not torn
always @(posedge I_SYS_CLK or negedge I_RSTN) begin
  if (!I_RSTN) begin
    mon_snap0 <= 32'h0;
    mon_snap1 <= 32'h0;
    mon_snap2 <= 32'h0;
    mon_snap3 <= 32'h0;
  end else if (I_CE && I_MON_SAMPLE && !mon_busy_q && !I_PASS_START) begin
    mon_snap0 <= I_MON_WORD0; // RULE_11
    mon_snap1 <= I_MON_WORD1;
    mon_snap2 <= I_MON_WORD2;
    mon_snap3 <= I_MON_WORD3;
  end
end

always @(posedge I_SYS_CLK or negedge I_RSTN) begin
  if (!I_RSTN) begin
    mon_busy_q <= 1'b0;
  end else if (I_CE) begin
    mon_busy_q <= O_MONITOR_BUSY || I_PASS_START;
  end
end

cpm_mon_shift u_mon_shift (
  .i_clk(I_SYS_CLK),
  .i_rstn(I_RSTN),
  .i_ce(I_CE),
  .i_enable(I_MONITOR_ENABLE), // RULE_13
  .i_start(I_PASS_START), // RULE_12
  .i_bit_tick(test_rise), // RULE_14
  .i_word0(mon_snap0),
  .i_word1(mon_snap1),
  .i_word2(mon_snap2),
  .i_word3(mon_snap3),
  .o_serial(O_TEST_MUX_OUT_PIN),
  .o_busy(O_MONITOR_BUSY)
);

endmodule

//--- cpm_map.vh
// constants for the pulse output and real-time monitor block
`ifndef CPM_MAP_VH
`define CPM_MAP_VH

// ----------------------------------------------------------------
// clocks and timing
// ----------------------------------------------------------------
`define CPM_SYS_HZ 200000000
`define CPM_SLOW_HZ 32768
`define CPM_FRAME_SLOW_CYCLES 13
`define CPM_ENGINE_CLK_NS 203
`define CPM_SLOTS_PER_FRAME 8
`define CPM_RELEASE_CYCLES ((`CPM_SYS_HZ / `CPM_SLOW_HZ) * `CPM_FRAME_SLOW_CYCLES / `CPM_SLOTS_PER_FRAME)
`define CPM_FRAME_CNT_LAST 4'hc

// ----------------------------------------------------------------
// sign fifo
// ----------------------------------------------------------------
`define CPM_FIFO_DEPTH 8
`define CPM_FIFO_AW 3
`define CPM_FIFO_FULL_CNT 4'h8
`define CPM_FIFO_REAL 0
`define CPM_FIFO_REACT 1

// ----------------------------------------------------------------
// pulse channel indices
// ----------------------------------------------------------------
`define CPM_CH_REACT 0
`define CPM_CH_REAL 1
`define CPM_CH_AUX1 2
`define CPM_CH_AUX2 3
`define CPM_NUM_PULSES 4

// ----------------------------------------------------------------
// monitor word framing
// ----------------------------------------------------------------
`define CPM_WORD_W 32
`define CPM_WORD_SLOTS 6'h23
`define CPM_BIT_LAST 6'h22
`define CPM_FLAG_SLOT 6'h00
`define CPM_DATA_LAST_SLOT 6'h20
`define CPM_WORD_LAST 2'h3

`endif

//--- cpm_rtm_shift.v
// serializer for the four monitored words on the test mux pin
`timescale 1ns/10ps
module cpm_mon_shift (
  // clock, reset, enable
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  // control
  input wire i_enable,
  input wire i_start,
  input wire i_bit_tick,
  // snapshot of the monitored words
  input wire [31:0] i_word0,
  input wire [31:0] i_word1,
  input wire [31:0] i_word2,
  input wire [31:0] i_word3,
  // serial output
  output reg o_serial,
  output reg o_busy
);

reg [1:0] word_idx;
reg [5:0] slot;
reg [31:0] shreg;
reg [31:0] next_word;

always @* begin
  case (word_idx)
    2'h0: next_word = i_word0;
    2'h1: next_word = i_word1;
    2'h2: next_word = i_word2;
    default: next_word = i_word3;
  endcase
end

// ----------------------------------------------------------------
// shifter: flag, then 32 bits msb first, then idle to fill the word
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_rstn) begin
  if (!i_rstn) begin
    word_idx <= 2'h0;
    slot <= 6'h00;
    shreg <= 32'h0;
    o_serial <= 1'b0;
    o_busy <= 1'b0;
  end else if (i_ce) begin
    if (!i_enable) begin
      // disabling aborts a stream in progress and parks the pin low
      o_busy <= 1'b0; // RULE_13
      o_serial <= 1'b0;
    end else if (i_start && !o_busy) begin
      o_busy <= 1'b1; // RULE_12
      word_idx <= 2'h0;
      slot <= `CPM_FLAG_SLOT;
      shreg <= i_word0; // RULE_18
    end else if (o_busy && i_bit_tick) begin // RULE_14
      if (slot == `CPM_FLAG_SLOT) begin
        o_serial <= 1'b1; // RULE_15
      end else if (slot <= `CPM_DATA_LAST_SLOT) begin
        o_serial <= shreg[31]; // RULE_18
        shreg <= {shreg[30:0], 1'b0};
      end else begin
        o_serial <= 1'b0;
      end
      if (slot == `CPM_BIT_LAST) begin // RULE_15
        slot <= `CPM_FLAG_SLOT;
        if (word_idx == `CPM_WORD_LAST) begin
          o_busy <= 1'b0;
        end else begin
          word_idx <= word_idx + 2'h1; // RULE_18
        end
      end else begin
        slot <= slot + 6'h01;
      end
    end else if (o_busy && slot == `CPM_FLAG_SLOT) begin
      shreg <= next_word;
    end else if (!o_busy) begin
      o_serial <= 1'b0;
    end
  end
end

endmodule

//--- cpm_pulse_out_props.sv
// port assertions for the pulse output and monitor block
`timescale 1ns/10ps
module cpm_pulse_out_props #(
  parameter RELEASE_CYCLES = 20
) (
  // clock, reset, enable
  input logic I_SYS_CLK,
  input logic I_RSTN,
  input logic I_CE,
  // inputs of the block
  input logic I_PASS_START,
  input logic I_AUX_STROBE,
  input logic I_AUX_FIRST,
  input logic I_AUX_SECOND,
  input logic I_PULSE_POLARITY_INVERT,
  input logic [3:0] I_IRQ_ENABLE,
  input logic I_MONITOR_ENABLE,
  input logic I_TEST_CLOCK,
  // outputs of the block
  input logic O_LCD_SHARED_IO_6,
  input logic O_LCD_SHARED_IO_7,
  input logic [3:0] O_PULSE_IRQ,
  input logic O_TEST_MUX_OUT_PIN,
  input logic O_MONITOR_BUSY
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RSTN);
  property p_aux_value;
    I_CE && I_AUX_STROBE && I_PASS_START ##1 I_CE |-> ##1
      {O_LCD_SHARED_IO_6, O_LCD_SHARED_IO_7} == ({$past(I_AUX_FIRST, 2),
      $past(I_AUX_SECOND, 2)} ^ {2{!$past(I_PULSE_POLARITY_INVERT)}});
  endproperty
  // a second strobe in the same pass must leave the pins alone
  property p_aux_once;
    I_CE && I_AUX_STROBE && I_PASS_START ##1 I_CE && !I_PASS_START
      ##1 I_CE && I_AUX_STROBE && !I_PASS_START
      ##1 I_CE && !I_PASS_START && $stable(I_PULSE_POLARITY_INVERT)
      |=> $stable({O_LCD_SHARED_IO_6, O_LCD_SHARED_IO_7});
  endproperty
  property p_irq_pulse;
    $past(I_CE) |-> (O_PULSE_IRQ & $past(O_PULSE_IRQ)) == 4'h0;
  endproperty
  property p_irq_gate;
    (O_PULSE_IRQ & ~$past(I_IRQ_ENABLE)) == 4'h0;
  endproperty
  property p_mon_start;
    I_CE && I_PASS_START && I_MONITOR_ENABLE && !O_MONITOR_BUSY |=> O_MONITOR_BUSY;
  endproperty
  property p_mon_off;
    I_CE && !I_MONITOR_ENABLE |=> !O_MONITOR_BUSY && !O_TEST_MUX_OUT_PIN;
  endproperty
  property p_mon_idle;
    !O_MONITOR_BUSY |-> !O_TEST_MUX_OUT_PIN;
  endproperty
  // a slot may only move after a test clock edge has come through the synchronizer
  property p_mon_pace;
    O_MONITOR_BUSY && $past(O_MONITOR_BUSY) && $changed(O_TEST_MUX_OUT_PIN) |->
      $past(I_TEST_CLOCK, 2) || $past(I_TEST_CLOCK, 3) || $past(I_TEST_CLOCK, 4);
  endproperty
  a_aux_value: assert property (p_aux_value) else $error("aux pin level wrong");
  a_aux_once: assert property (p_aux_once) else $error("aux pin moved twice");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  a_irq_gate: assert property (p_irq_gate) else $error("masked irq raised");
  a_mon_start: assert property (p_mon_start) else $error("stream not started");
  a_mon_off: assert property (p_mon_off) else $error("monitor not stopped");
  a_mon_idle: assert property (p_mon_idle) else $error("pin busy while idle");
  a_mon_pace: assert property (p_mon_pace) else $error("slot without tick");
  c_aux: cover property (I_AUX_STROBE && I_PASS_START);
  c_irq: cover property (|O_PULSE_IRQ);
  c_stream: cover property ($fell(O_MONITOR_BUSY));
endmodule
bind cpm_pulse_out cpm_pulse_out_props #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_props (
  .I_SYS_CLK, .I_RSTN, .I_CE, .I_PASS_START, .I_AUX_STROBE, .I_AUX_FIRST, .I_AUX_SECOND,
  .I_PULSE_POLARITY_INVERT, .I_IRQ_ENABLE, .I_MONITOR_ENABLE, .I_TEST_CLOCK,
  .O_LCD_SHARED_IO_6, .O_LCD_SHARED_IO_7, .O_PULSE_IRQ, .O_TEST_MUX_OUT_PIN, .O_MONITOR_BUSY);

//--- cpm_far_model.sv
// external clock sources seen on the block's pins
`timescale 1ns/10ps
module cpm_far_model (
  // gates
  input wire i_slow_run,
  input wire i_test_run,
  // clock pins
  output reg o_slow_clk,
  output reg o_test_clk
);
  initial begin
    o_slow_clk = 1'b0;
    o_test_clk = 1'b0;
  end
  // stands still when gated so slot spacing is not disturbed by frame starts
  always begin
    #50;
    o_slow_clk = i_slow_run ? ~o_slow_clk : 1'b0;
  end
  // test clock only runs while a stream is expected
  always begin
    #24;
    o_test_clk = i_test_run ? ~o_test_clk : 1'b0;
  end
endmodule

//--- testbench.sv
// self-checking bench for the pulse outputs and monitor stream
`timescale 1ns/10ps
module testbench;
  localparam REL = 20;
  localparam FRAME = 13;
  // push to pin: release tick, pop, pin register
  localparam FRAME_POP = 3;
  reg clk, rstn, ce, pass, sstb, rs, xs, astb, a1, a2, inv, men, msamp, srun, trun;
  reg [3:0] irqen;
  reg [31:0] w [0:3];
  wire slow, tclk, p_react, p_real, p6, p7, tpin, busy;
  wire [3:0] irq;
  integer bad_count, comparisons;
  cpm_far_model far (.i_slow_run(srun), .i_test_run(trun), .o_slow_clk(slow), .o_test_clk(tclk));
  cpm_pulse_out #(.RELEASE_CYCLES(REL)) dut (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_CE(ce),
    .I_PASS_START(pass), .I_SIGN_STROBE(sstb), .I_REAL_SIGN(rs), .I_REACT_SIGN(xs),
    .I_AUX_STROBE(astb), .I_AUX_FIRST(a1), .I_AUX_SECOND(a2), .I_PULSE_POLARITY_INVERT(inv),
    .I_IRQ_ENABLE(irqen), .I_MONITOR_ENABLE(men), .I_MON_SAMPLE(msamp), .I_MON_WORD0(w[0]),
    .I_MON_WORD1(w[1]), .I_MON_WORD2(w[2]), .I_MON_WORD3(w[3]), .I_SLOW_32K_CLOCK(slow),
    .I_TEST_CLOCK(tclk), .O_REACTIVE_ENERGY_PULSE(p_react), .O_REAL_ENERGY_PULSE(p_real),
    .O_LCD_SHARED_IO_6(p6), .O_LCD_SHARED_IO_7(p7), .O_PULSE_IRQ(irq),
    .O_TEST_MUX_OUT_PIN(tpin), .O_MONITOR_BUSY(busy));
  // ----------------
  // shared tasks
  // ----------------
  task check(input string what, input [31:0] seen, input [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // bounded wait for the real pulse pin to move; 200 means it never did
  task wait_chg(output integer n);
    reg was;
    was = p_real;
    n = 0;
    while (p_real === was && n < 200) begin
      @(negedge clk);
      n = n + 1;
    end
  endtask
  task aux(input ps, input st, input f, input s);
    {pass, astb, a1, a2} = {ps, st, f, s};
    @(negedge clk);
    {pass, astb} = 2'h0;
    @(negedge clk);
  endtask
  // ----------------
  // scenarios
  // ----------------
  task t_fifo;
    integer i, n;
    reg [8:0] rb;
    rb = 9'h14d;
    {sstb, rs, xs} = 3'h6;
    @(negedge clk);
    sstb = 1'b0;
    wait_chg(n);
    check("first pop", p_real, 1'b1);
    sstb = 1'b1;
    // nine pushes right after a pop: the ninth meets a full buffer
    for (i = 0; i < 9; i = i + 1) begin
      rs = (i == 8) ? 1'b0 : i[0];
      xs = rb[i];
      @(negedge clk);
    end
    sstb = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      wait_chg(n);
      if (i > 0)
        check("pop spacing", n, REL);
      check("pop pair", {p_react, p_real}, {rb[i], i[0]});
      check("pop irq", irq[1:0], {i[0], 1'b0});
    end
    wait_chg(n);
    check("dropped push", n, 200);
    $display("fifo test done");
  endtask
  // runs straight after the fifo test, so slow edges fall mid-slot and a
  // frame start shows up as a release well ahead of the free-running slot
  task t_frame;
    integer n;
    srun = 1'b1;
    repeat (FRAME) @(posedge slow);
    @(posedge clk);
    @(negedge clk);
    {sstb, rs, xs} = 3'h4;
    @(negedge clk);
    sstb = 1'b0;
    wait_chg(n);
    check("frame release", n, FRAME_POP);
    check("frame sign", p_real, 1'b0);
    srun = 1'b0;
    $display("frame test done");
  endtask
  task t_aux;
    integer p;
    for (p = 0; p < 2; p = p + 1) begin
      inv = p[0];
      aux(1'b1, 1'b1, 1'b1, 1'b0);
      check("aux set", {p6, p7}, p ? 2'h2 : 2'h1);
      check("aux irq", irq[3:2], 2'h1);
      aux(1'b0, 1'b1, 1'b0, 1'b1);
      check("aux repeat", {p6, p7}, p ? 2'h2 : 2'h1);
      aux(1'b1, 1'b0, 1'b0, 1'b1);
      aux(1'b0, 1'b1, 1'b0, 1'b1);
      check("aux next pass", {p6, p7}, p ? 2'h1 : 2'h2);
      check("aux masked irq", irq[3:2], 2'h0);
    end
    // with the clock enable low neither a strobe nor the polarity may move a pin
    ce = 1'b0;
    inv = 1'b0;
    aux(1'b1, 1'b1, 1'b0, 1'b0);
    check("frozen pins", {p6, p7}, 2'h1);
    {ce, inv} = 2'h3;
    repeat (2) @(negedge clk);
    check("strobe while frozen", {p6, p7}, 2'h1);
    $display("aux test done");
  endtask
  task t_mon;
    integer k, b;
    reg [34:0] slot;
    {men, msamp} = 2'h3;
    @(negedge clk);
    msamp = 1'b0;
    @(negedge clk);
    pass = 1'b1;
    @(negedge clk);
    pass = 1'b0;
    check("busy at start", busy, 1'b1);
    trun = 1'b1;
    for (k = 0; k < 4; k = k + 1) begin
      slot = {1'b1, w[k], 2'h0};
      for (b = 34; b >= 0; b = b - 1) begin
        @(posedge tclk);
        #30;
        check("monitor slot", tpin, slot[b]);
      end
    end
    trun = 1'b0;
    repeat (4) @(negedge clk);
    check("busy after words", busy, 1'b0);
    pass = 1'b1;
    @(negedge clk);
    {pass, trun} = 2'h1;
    repeat (5) @(posedge tclk);
    @(negedge clk);
    {men, trun} = 2'h0;
    repeat (2) @(negedge clk);
    check("monitor off", {busy, tpin}, 2'h0);
    $display("monitor test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    bad_count = bad_count + 1;
    summarize;
  end
  initial begin
    {pass, sstb, rs, xs, astb, a1, a2, men, msamp, srun, trun, rstn} = 12'h0;
    {ce, inv} = 2'h3;
    irqen = 4'h6;
    bad_count = 0;
    comparisons = 0;
    {w[0], w[1]} = {32'h8000_0001, 32'h5a5a_c3c3};
    {w[2], w[3]} = {32'h0000_0000, 32'hffff_fffe};
    repeat (12) @(negedge clk);
    check("pins in reset", {p_react, p_real, p6, p7}, 4'hf);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    check("pins idle", {p_react, p_real, p6, p7}, 4'h0);
    t_fifo;
    t_frame;
    t_aux;
    t_mon;
    summarize;
  end
endmodule
